// [common/uvpc_cfg.svh]
`ifndef UVPC_CFG_SVH
`define UVPC_CFG_SVH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define UVPC_ADDR_W 15
`define UVPC_DATA_W 8
`define UVPC_LAST_ADDR 15'h7FFF
`define UVPC_ERASED 8'hFF
`define UVPC_ID_LINE 9
// ----------------------------------------
// Timing, clock 20 MHz
// ----------------------------------------
`define UVPC_CLK_HZ 20000000
`define UVPC_PULSE_US 100
`define UVPC_PULSE_CYC ((`UVPC_PULSE_US * `UVPC_CLK_HZ) / 1000000)
`define UVPC_SETTLE_NS 200
`define UVPC_SETTLE_CYC \
  ((`UVPC_SETTLE_NS * (`UVPC_CLK_HZ / 1000000) + 999) / 1000)
`define UVPC_MAX_PULSES 10
`define UVPC_SYNC_WAIT 16'h0002
`define UVPC_CNT_W 16
`endif

// [common/uvpc_pkg.sv]
`default_nettype none
package uvpc_pkg;
  typedef enum logic [1:0] {
    UVPC_OP_READ  = 2'h0,
    UVPC_OP_PROG  = 2'h1,
    UVPC_OP_SIG   = 2'h2,
    UVPC_OP_CHECK = 2'h3
  } uvpc_op_t;

  // Pin bundle towards the memory
  typedef struct packed {
    logic [14:0] word_address;
    logic        chip_sel_n;
    logic        out_gate_n;
    logic        prog_supply_hi;
    logic        main_supply_prog;
    logic        identifier_pin_hi;
  } uvpc_pins_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ok;
    logic       failed;
  } uvpc_result_t;
endpackage : uvpc_pkg
`default_nettype wire

// [logic/uvpc_ctrl.sv]
// Contract
// R1 - Memory is 32768 bytes, 15 address lines, full byte per access.
// R2 - Read: select low, gate low, normal supply; device drives byte.
// R3 - Only one shared device may have select and gate both low.
// R4 - Select high means standby, data lines floating.
// R5 - Blank reads all ones; programming only clears bits.
// R6 - One-time variant can never restore programmed zeros.
// R7 - Program entry: supply 13 V, main 6.5 V, gate high, pulse select.
// R8 - Address and data settle before the select pulse.
// R9 - 100 us pulses, verify each, fail byte after 10 pulses.
// R10 - Verify: high supply, gate low, select high; device drives byte.
// R11 - Select high inhibits programming, data lines floating.
// R12 - After programming, verify all locations at 5 V supplies.
// R13 - Locations may be programmed in any address order.
// R14 - Signature when identifier pin high voltage, select and gate low.
// R15 - Code select low gives maker code, high device code; others low.
// R16 - Model erases to ones and programs by AND.
`timescale 1ns/1ns
`default_nettype none
`include "uvpc_cfg.svh"

module uvpc_ctrl #(
  parameter int PULSE_CYC  = `UVPC_PULSE_CYC,
  parameter int SETTLE_CYC = `UVPC_SETTLE_CYC,
  parameter int MAX_PULSES = `UVPC_MAX_PULSES
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 clk_en,
  // Command side
  input  wire logic                 cmd_valid,
  input  wire uvpc_pkg::uvpc_op_t   cmd_op,
  input  wire logic [14:0]          cmd_addr,
  input  wire logic [7:0]           cmd_data,
  input  wire logic                 cmd_code_sel,
  output logic                      cmd_ready,
  output var uvpc_pkg::uvpc_result_t rsp,
  output logic                      rsp_valid,
  // Memory pins
  output var uvpc_pkg::uvpc_pins_t  pins,
  output logic [7:0]                data_lines_o,
  output logic                      data_lines_oe_n,
  input  wire logic [7:0]           data_lines_i
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_SETUP  = 3'b001,
    S_PULSE  = 3'b010,
    S_VSET   = 3'b011,
    S_VSAMP  = 3'b100,
    S_RSET   = 3'b101,
    S_RSAMP  = 3'b110
  } uvpc_state_t;

  uvpc_state_t      state;
  uvpc_pkg::uvpc_op_t op;
  logic [15:0]      cnt;
  logic [3:0]       tries;
  logic [7:0]       wdata;
  logic [7:0]       sync1;
  logic [7:0]       sync2;

  function automatic logic [15:0] cyc(input int n);
    cyc = 16'(n - 1);
  endfunction : cyc

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Pin data passes two flops before use
  // Bus turns around freely, one flop could hand a metastable byte on
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else if (clk_en) begin
      sync1 <= data_lines_i;
      sync2 <= sync1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state           <= S_IDLE;
      op              <= uvpc_pkg::UVPC_OP_READ;
      cnt             <= 16'h0000;
      tries           <= 4'h0;
      wdata           <= 8'hFF;
      cmd_ready       <= 1'b1;
      rsp             <= '0;
      rsp_valid       <= 1'b0;
      pins            <= '{word_address: 15'h0000, chip_sel_n: 1'b1,
                           out_gate_n: 1'b1, prog_supply_hi: 1'b0,
                           main_supply_prog: 1'b0,
                           identifier_pin_hi: 1'b0};
      data_lines_o    <= 8'hFF;
      data_lines_oe_n <= 1'b1;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            op        <= cmd_op;
            wdata     <= cmd_data;
            tries     <= 4'h0;
            cnt       <= cyc(SETTLE_CYC);
            pins.word_address <= cmd_addr; // R1 R13
            pins.chip_sel_n   <= 1'b1; // R4
            pins.out_gate_n   <= 1'b1; // R3
            if (cmd_op == uvpc_pkg::UVPC_OP_PROG) begin
              pins.prog_supply_hi   <= 1'b1; // R7
              pins.main_supply_prog <= 1'b1; // R7
              data_lines_o    <= cmd_data; // R8
              data_lines_oe_n <= 1'b0;
              state <= S_SETUP;
            end else begin
              pins.prog_supply_hi   <= 1'b0; // R12
              pins.main_supply_prog <= 1'b0; // R12
              if (cmd_op == uvpc_pkg::UVPC_OP_SIG) begin
                // Only code select may be high besides the id pin
                pins.word_address <= 15'(cmd_code_sel); // R15
                pins.word_address[`UVPC_ID_LINE] <= 1'b1; // R14
                pins.identifier_pin_hi <= 1'b1; // R14
              end
              state <= S_RSET;
            end
          end
        end
        S_SETUP: begin
          if (cnt == 16'h0000) begin
            pins.chip_sel_n <= 1'b0; // R7 R8
            cnt   <= cyc(PULSE_CYC); // R9
            tries <= tries + 4'h1;
            state <= S_PULSE;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_PULSE: begin
          if (cnt == 16'h0000) begin
            // Select high inhibits further writing while we verify
            pins.chip_sel_n <= 1'b1; // R11
            data_lines_oe_n <= 1'b1;
            cnt   <= cyc(SETTLE_CYC);
            state <= S_VSET;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_VSET: begin
          pins.out_gate_n <= 1'b0; // R10
          if (cnt == 16'h0000) begin
            cnt   <= `UVPC_SYNC_WAIT; // sync latency
            state <= S_VSAMP;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_VSAMP: begin
          if (cnt == 16'h0000) begin
            pins.out_gate_n <= 1'b1;
            if (sync2 == wdata || tries == 4'(MAX_PULSES)) begin // R9
              rsp       <= '{data: sync2, ok: (sync2 == wdata),
                             failed: (sync2 != wdata)};
              rsp_valid <= 1'b1;
              pins.prog_supply_hi   <= 1'b0;
              pins.main_supply_prog <= 1'b0;
              cmd_ready <= 1'b1;
              state     <= S_IDLE;
            end else begin
              data_lines_o    <= wdata; // R8
              data_lines_oe_n <= 1'b0;
              cnt   <= cyc(SETTLE_CYC);
              state <= S_SETUP;
            end
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_RSET: begin
          pins.chip_sel_n <= 1'b0; // R2 R14
          pins.out_gate_n <= 1'b0; // R2 R3
          if (cnt == 16'h0000) begin
            cnt   <= `UVPC_SYNC_WAIT;
            state <= S_RSAMP;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        S_RSAMP: begin
          if (cnt == 16'h0000) begin
            pins.chip_sel_n <= 1'b1; // R4
            pins.out_gate_n <= 1'b1;
            pins.identifier_pin_hi <= 1'b0;
            rsp       <= '{data: sync2,
                           ok: (op != uvpc_pkg::UVPC_OP_CHECK) ||
                               (sync2 == wdata), // R12
                           failed: (op == uvpc_pkg::UVPC_OP_CHECK) &&
                                   (sync2 != wdata)};
            rsp_valid <= 1'b1;
            cmd_ready <= 1'b1;
            state     <= S_IDLE;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule : uvpc_ctrl
`default_nettype wire

// [verification/uvpc_ctrl_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module uvpc_ctrl_chk #(
  parameter int PULSE_CYC = 8
) (
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 arst_n,
  // Watched ports
  input wire logic                 clk_en,
  input wire logic                 cmd_valid,
  input wire uvpc_pkg::uvpc_op_t   cmd_op,
  input wire logic                 cmd_ready,
  input wire logic                 rsp_valid,
  input wire uvpc_pkg::uvpc_pins_t pins,
  input wire logic                 data_lines_oe_n
);
  logic [15:0] low_cnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // Select pulse length
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      low_cnt <= 16'h0000;
    else if (pins.chip_sel_n)
      low_cnt <= 16'h0000;
    else if (clk_en)
      low_cnt <= low_cnt + 16'h0001;
  end
  a_no_contention: assert property (
    !pins.out_gate_n |-> data_lines_oe_n) else $error("data clash");
  a_prog_gate: assert property (
    pins.prog_supply_hi && !pins.chip_sel_n |->
    pins.out_gate_n && !data_lines_oe_n) else $error("prog pins");
  a_vcc_with_vpp: assert property (
    $rose(pins.prog_supply_hi) |-> pins.main_supply_prog)
    else $error("main supply late");
  a_settle_first: assert property (
    $fell(pins.chip_sel_n) && pins.prog_supply_hi |->
    !$past(data_lines_oe_n) && $stable(pins.word_address))
    else $error("pulse before settle");
  a_pulse_len: assert property (
    $rose(pins.chip_sel_n) && pins.prog_supply_hi |->
    low_cnt == PULSE_CYC) else $error("pulse length");
  a_sig_addr: assert property (
    pins.identifier_pin_hi |-> pins.word_address[14:1] == 14'h0100
    && !pins.prog_supply_hi) else $error("signature address");
  a_take_busy: assert property (
    cmd_valid && cmd_ready && clk_en |=> !cmd_ready)
    else $error("ready after take");
  a_rsp_once: assert property (
    rsp_valid |-> cmd_ready ##1 !rsp_valid) else $error("rsp pulse");
  a_read_done: assert property (
    cmd_valid && cmd_ready && clk_en && cmd_op == uvpc_pkg::UVPC_OP_READ
    |-> ##[2:40] rsp_valid) else $error("read late");
  a_idle_pins: assert property (
    rsp_valid |-> pins.chip_sel_n && !pins.prog_supply_hi)
    else $error("pins left active");
endmodule : uvpc_ctrl_chk
`default_nettype wire

// [verification/uvpc_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module uvpc_mem_model #(
  parameter logic [7:0] MAKER_CODE = 8'hA1, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3C  // Arbitrary value
) (
  // Pins and bus
  input  wire uvpc_pkg::uvpc_pins_t pins,
  input  wire logic [7:0]           din,
  output logic [7:0]                dout,
  output logic                      drive
);
  logic [7:0] mem [0:32767];
  logic [7:0] last;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    last = 8'h00;
  end
  // Released lines show the inverse, never a stale byte
  always_comb begin
    drive = 1'b0;
    dout = ~last;
    if (!pins.chip_sel_n && !pins.out_gate_n && pins.identifier_pin_hi) begin
      drive = 1'b1;
      dout = pins.word_address[0] ? PART_CODE : MAKER_CODE;
    end else if (!pins.out_gate_n && pins.chip_sel_n == pins.prog_supply_hi) begin
      drive = 1'b1;
      dout = mem[pins.word_address];
    end
  end
  always @(dout or drive) if (drive) last = dout;
  // Written as the pulse starts: the data lines are released as it ends
  always @(negedge pins.chip_sel_n)
    if (pins.prog_supply_hi && pins.main_supply_prog && pins.out_gate_n)
      mem[pins.word_address] = mem[pins.word_address] & din;
endmodule : uvpc_mem_model
`default_nettype wire

// [verification/uvpc_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module uvpc_ctrl_tb;
  typedef struct packed {
    logic [1:0]  op;
    logic [14:0] a;
    logic [7:0]  d;
    logic        s;
    logic [7:0]  q;
    logic [1:0]  k;
    logic [2:0]  m;
  } uvpc_row_t;
  logic mclk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_code_sel = 1'b0;
  logic clk_en = 1'b1;
  logic cmd_ready, rsp_valid, oe_n, m_drv;
  uvpc_pkg::uvpc_op_t cmd_op = uvpc_pkg::UVPC_OP_READ;
  logic [14:0] cmd_addr = 15'h0000;
  logic [7:0] cmd_data = 8'h00, d_o, m_q, bus;
  uvpc_pkg::uvpc_result_t rsp;
  uvpc_pkg::uvpc_pins_t pins;
  int fails = 0, num_checks = 0;
  // Rows: op addr data sel, byte, {ok,failed}, mask {failed,ok,byte}
  uvpc_row_t rows [10] = '{
    '{2'h0, 15'h7FFF, 8'h00, 1'h0, 8'hFF, 2'h0, 3'h1},
    '{2'h1, 15'h1234, 8'hA5, 1'h0, 8'h00, 2'h2, 3'h6},
    '{2'h0, 15'h1234, 8'h00, 1'h0, 8'hA5, 2'h0, 3'h1},
    '{2'h1, 15'h1234, 8'h3C, 1'h0, 8'h00, 2'h1, 3'h6},
    '{2'h3, 15'h1234, 8'h24, 1'h0, 8'h24, 2'h2, 3'h3},
    '{2'h3, 15'h1234, 8'hA5, 1'h0, 8'h00, 2'h0, 3'h2},
    '{2'h2, 15'h0000, 8'h00, 1'h0, 8'hA1, 2'h0, 3'h1},
    '{2'h2, 15'h0000, 8'h00, 1'h1, 8'h3C, 2'h0, 3'h1},
    '{2'h1, 15'h0001, 8'h00, 1'h0, 8'h00, 2'h2, 3'h6},
    '{2'h0, 15'h0001, 8'h00, 1'h0, 8'h00, 2'h0, 3'h1}};
  always #25 mclk = ~mclk;
  assign bus = !oe_n ? d_o : m_q;
  uvpc_ctrl #(.PULSE_CYC(8)) i_dut (.mclk(mclk), .arst_n(arst_n),
    .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_code_sel(cmd_code_sel),
    .cmd_ready(cmd_ready), .rsp(rsp), .rsp_valid(rsp_valid), .pins(pins),
    .data_lines_o(d_o), .data_lines_oe_n(oe_n), .data_lines_i(bus));
  uvpc_mem_model i_mem (.pins(pins), .din(bus), .dout(m_q), .drive(m_drv));
  task automatic check(input string name, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic start(input uvpc_row_t r);
    @(negedge mclk);
    while (cmd_ready !== 1'b1) @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = uvpc_pkg::uvpc_op_t'(r.op);
    cmd_addr = r.a;
    cmd_data = r.d;
    cmd_code_sel = r.s;
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask : start
  task automatic run(input uvpc_row_t r);
    start(r);
    await_rsp(r);
  endtask : run
  task automatic await_rsp(input uvpc_row_t r);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    check("rsp_valid", {7'h00, rsp_valid}, 8'h01);
    if (r.m[0]) check("data", rsp.data, r.q);
    if (r.m[1]) check("ok", {7'h00, rsp.ok}, {7'h00, r.k[1]});
    if (r.m[2]) check("failed", {7'h00, rsp.failed}, {7'h00, r.k[0]});
  endtask : await_rsp
  // Idle pins: select, gate, vpp, vcc, id, oe_n, ready, rsp_valid
  task automatic idle(input string name);
    check(name, {pins.chip_sel_n, pins.out_gate_n, pins.prog_supply_hi,
      pins.main_supply_prog, pins.identifier_pin_hi, oe_n, cmd_ready,
      rsp_valid}, 8'hC6);
    check({name, " drive"}, {7'h00, m_drv}, 8'h00);
  endtask : idle
  initial begin
    repeat (12) @(negedge mclk);
    idle("reset");
    arst_n = 1'b1;
    foreach (rows[i]) run(rows[i]);
    // Clock enable low freezes a read just after it is taken
    start(rows[9]);
    clk_en = 1'b0;
    repeat (20) @(negedge mclk);
    check("frozen", {6'h00, cmd_ready, rsp_valid}, 8'h00);
    clk_en = 1'b1;
    await_rsp(rows[9]);
    // Reset in the middle of a pulse must drop select and supplies
    start(rows[1]);
    repeat (10) @(negedge mclk);
    check("pulse", {7'h00, pins.chip_sel_n}, 8'h00);
    arst_n = 1'b0;
    #1 idle("abort");
    @(negedge mclk);
    arst_n = 1'b1;
    run(rows[0]);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    summarize();
  end
endmodule : uvpc_ctrl_tb
bind uvpc_ctrl uvpc_ctrl_chk #(.PULSE_CYC(PULSE_CYC)) i_chk (
  .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .pins(pins), .data_lines_oe_n(data_lines_oe_n));
`default_nettype wire
